// ==== src/xfer_pkg.sv ====
// shared constants and types for the transfer and ram-move datapath
package xfer_pkg;

   // register widths
   localparam int NIB_W = 4;
   localparam int D_W = 3;
   localparam int Z_W = 2;
   localparam int STACK_PTR_W = 3;
   localparam int E_W = 8;
   localparam int IMM_W = 8;
   localparam int DATA_PTR_W = Z_W + 2 * NIB_W;

   // values after reset
   localparam logic [3:0] NIB_RST = 4'h0;
   localparam logic [2:0] D_RST = 3'h0;
   localparam logic [1:0] Z_RST = 2'h0;
   localparam logic [7:0] E_RST = 8'h00;

   // wrap values that decide a skip
   localparam logic [3:0] Y_INC_WRAP = 4'h0;
   localparam logic [3:0] Y_DEC_WRAP = 4'hF;

   // immediate field positions
   localparam int IMM_X_LSB = 4;
   localparam int IMM_Y_LSB = 0;
   localparam int IMM_J_LSB = 0;
   localparam int IMM_Z_LSB = 0;

   // cycles from acceptance to completion, equal for every instruction
   localparam int EXEC_CYCLES = 2;

   typedef enum logic [4:0] {
      OP_OTHER = 5'h00,
      OP_COPY_B_INTO_ACC = 5'h01,
      OP_COPY_ACC_INTO_B = 5'h02,
      OP_COPY_Y_INTO_ACC = 5'h03,
      OP_COPY_ACC_INTO_Y = 5'h04,
      OP_PACK_AB_INTO_E = 5'h05,
      OP_UNPACK_E_INTO_AB = 5'h06,
      OP_WRITE_ACC_TO_D = 5'h07,
      OP_READ_D_TO_ACC = 5'h08,
      OP_READ_Z_TO_ACC = 5'h09,
      OP_READ_X_TO_ACC = 5'h0A,
      OP_READ_STACK_PTR_TO_ACC = 5'h0B,
      OP_LOAD_X_Y_IMM = 5'h0C,
      OP_LOAD_Z_IMM = 5'h0D,
      OP_INCREMENT_Y_SKIP = 5'h0E,
      OP_DECREMENT_Y_SKIP = 5'h0F,
      OP_LOAD_ACC_FROM_MEM = 5'h10,
      OP_EXCHANGE_ACC_MEM = 5'h11,
      OP_EXCHANGE_ACC_MEM_DEC = 5'h12,
      OP_EXCHANGE_ACC_MEM_INC = 5'h13,
      OP_STORE_ACC_TO_MEM = 5'h14
   } op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } state_t;

endpackage : xfer_pkg

// ==== src/nibble_ram.sv ====
// data ram of nibbles with registered read data
`timescale 1ns/1ps
`default_nettype none
module nibble_ram #(
   parameter int ADDR_W = 10,
   parameter int DATA_W = 4
) (
   // clock
   input wire logic clk,
   // read port
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data,
   // write port
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data
);

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // contents hold no reset, as real ram does
   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule : nibble_ram
`default_nettype wire

// ==== src/xfer_exec.sv ====
// transfer, ram-address and ram-move execution datapath of a 4-bit core
`timescale 1ns/1ps
`default_nettype none
module xfer_exec
   import xfer_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // instruction from decoder
   input wire logic cmd_valid,
   input wire op_t cmd_op,
   input wire logic [IMM_W-1:0] cmd_imm,
   output logic cmd_ready,
   // state from the rest of the core
   input wire logic [STACK_PTR_W-1:0] stack_pointer,
   // completion
   output logic done,
   output logic skipped,
   // register file view
   output logic [NIB_W-1:0] acc,
   output logic [NIB_W-1:0] reg_b,
   output logic [NIB_W-1:0] reg_x,
   output logic [NIB_W-1:0] reg_y,
   output logic [Z_W-1:0] reg_z,
   output logic [D_W-1:0] reg_d,
   output logic [E_W-1:0] reg_e
);

   state_t state_q;
   op_t op_q;
   logic [IMM_W-1:0] imm_q;
   logic ready_q, done_q, skipped_q, skip_pend_q, xy_load_prev_q;
   logic [NIB_W-1:0] acc_q, b_q, x_q, y_q;
   logic [Z_W-1:0] z_q;
   logic [D_W-1:0] d_q;
   logic [E_W-1:0] e_q;
   logic [NIB_W-1:0] mem_rd, j_imm, y_inc, y_dec;
   logic [DATA_PTR_W-1:0] data_pointer;
   logic accept, in_exec, skip_now, run, mem_op, xor_op, mem_wr;

   assign accept = cmd_valid && ready_q;
   assign in_exec = (state_q == ST_EXEC);
   // run of x-y loads: an x-y immediate load after an x-y immediate load is skipped
   assign skip_now = skip_pend_q
      || (op_q == OP_LOAD_X_Y_IMM && xy_load_prev_q);
   // skip as nop: register file and ram write below update only when run
   assign run = in_exec && !skip_now;
   assign data_pointer = {z_q, x_q, y_q};
   assign j_imm = imm_q[IMM_J_LSB +: NIB_W];
   assign y_inc = y_q + 4'h1;
   assign y_dec = y_q - 4'h1;
   assign mem_op = (op_q == OP_EXCHANGE_ACC_MEM)
      || (op_q == OP_EXCHANGE_ACC_MEM_DEC)
      || (op_q == OP_EXCHANGE_ACC_MEM_INC);
   assign xor_op = mem_op || (op_q == OP_LOAD_ACC_FROM_MEM)
      || (op_q == OP_STORE_ACC_TO_MEM);
   assign mem_wr = run && (mem_op || op_q == OP_STORE_ACC_TO_MEM);

   // read issued at acceptance so the nibble is ready in the exec cycle;
   // the pointer cannot move in between because only exec changes it
   nibble_ram #(
      .ADDR_W(DATA_PTR_W),
      .DATA_W(NIB_W)
   ) u_ram (
      .clk(clk),
      .rd_en(accept),
      .rd_addr(data_pointer),
      .rd_data(mem_rd),
      .wr_en(mem_wr),
      .wr_addr(data_pointer),
      .wr_data(acc_q)
   );

   // two-cycle sequencer, same length for executed and skipped work
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         ready_q <= 1'b1;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (accept) begin
                  state_q <= ST_EXEC;
                  ready_q <= 1'b0;
               end
            end
            ST_EXEC: begin
               state_q <= ST_IDLE;
               ready_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         op_q <= OP_OTHER;
         imm_q <= 8'h00;
      end else if (accept) begin
         op_q <= cmd_op;
         imm_q <= cmd_imm;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         done_q <= 1'b0;
         skipped_q <= 1'b0;
      end else begin
         done_q <= in_exec;
         skipped_q <= in_exec && skip_now;
      end
   end

   // skip request for the next instruction; consumed by the one it skips
   always_ff @(posedge clk) begin
      if (srst) begin
         skip_pend_q <= 1'b0;
         xy_load_prev_q <= 1'b0;
      end else if (in_exec) begin
         xy_load_prev_q <= (op_q == OP_LOAD_X_Y_IMM);
         skip_pend_q <= 1'b0;
         if (run) begin
            unique case (op_q)
               OP_INCREMENT_Y_SKIP: skip_pend_q <= (y_inc == Y_INC_WRAP);
               OP_EXCHANGE_ACC_MEM_INC: skip_pend_q <= (y_inc == Y_INC_WRAP);
               OP_DECREMENT_Y_SKIP: skip_pend_q <= (y_dec == Y_DEC_WRAP);
               OP_EXCHANGE_ACC_MEM_DEC: skip_pend_q <= (y_dec == Y_DEC_WRAP);
               default: skip_pend_q <= 1'b0;
            endcase
         end
      end
   end

   // carry untouched: this block holds no path to the carry flag
   always_ff @(posedge clk) begin
      if (srst) begin
         acc_q <= NIB_RST;
      end else if (run) begin
         unique case (op_q)
            OP_COPY_B_INTO_ACC: acc_q <= b_q;
            OP_COPY_Y_INTO_ACC: acc_q <= y_q;
            OP_UNPACK_E_INTO_AB: acc_q <= e_q[3:0];
            OP_READ_D_TO_ACC: acc_q <= {1'b0, d_q};
            OP_READ_Z_TO_ACC: acc_q <= {2'b00, z_q};
            OP_READ_X_TO_ACC: acc_q <= x_q;
            OP_READ_STACK_PTR_TO_ACC: acc_q <= {1'b0, stack_pointer};
            OP_LOAD_ACC_FROM_MEM, OP_EXCHANGE_ACC_MEM,
            OP_EXCHANGE_ACC_MEM_DEC, OP_EXCHANGE_ACC_MEM_INC: acc_q <= mem_rd;
            default: acc_q <= acc_q;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         b_q <= NIB_RST;
      end else if (run) begin
         if (op_q == OP_COPY_ACC_INTO_B) begin
            b_q <= acc_q;
         end else if (op_q == OP_UNPACK_E_INTO_AB) begin
            b_q <= e_q[7:4];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         x_q <= NIB_RST;
      end else if (run) begin
         if (op_q == OP_LOAD_X_Y_IMM) begin
            x_q <= imm_q[IMM_X_LSB +: NIB_W];
         end else if (xor_op) begin
            x_q <= x_q ^ j_imm;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         y_q <= NIB_RST;
      end else if (run) begin
         unique case (op_q)
            OP_COPY_ACC_INTO_Y: y_q <= acc_q;
            OP_LOAD_X_Y_IMM: y_q <= imm_q[IMM_Y_LSB +: NIB_W];
            OP_INCREMENT_Y_SKIP, OP_EXCHANGE_ACC_MEM_INC: y_q <= y_inc;
            OP_DECREMENT_Y_SKIP, OP_EXCHANGE_ACC_MEM_DEC: y_q <= y_dec;
            default: y_q <= y_q;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         z_q <= Z_RST;
         d_q <= D_RST;
         e_q <= E_RST;
      end else if (run) begin
         if (op_q == OP_LOAD_Z_IMM) begin
            z_q <= imm_q[IMM_Z_LSB +: Z_W];
         end
         if (op_q == OP_WRITE_ACC_TO_D) begin
            d_q <= acc_q[D_W-1:0];
         end
         if (op_q == OP_PACK_AB_INTO_E) begin
            e_q <= {b_q, acc_q};
         end
      end
   end

   assign cmd_ready = ready_q;
   assign done = done_q;
   assign skipped = skipped_q;
   assign acc = acc_q;
   assign reg_b = b_q;
   assign reg_x = x_q;
   assign reg_y = y_q;
   assign reg_z = z_q;
   assign reg_d = d_q;
   assign reg_e = e_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_b_to_acc: assert property (
      run && op_q == OP_COPY_B_INTO_ACC |=> acc_q == $past(b_q)
         && b_q == $past(b_q)) else $error("acc not loaded from b");
   a_acc_to_b: assert property (
      run && op_q == OP_COPY_ACC_INTO_B |=> b_q == $past(acc_q)
         && acc_q == $past(acc_q)) else $error("b not loaded from acc");
   a_pack_e: assert property (
      run && op_q == OP_PACK_AB_INTO_E |=> e_q == {$past(b_q), $past(acc_q)})
      else $error("pack wrong");
   a_read_d_acc: assert property (
      run && op_q == OP_READ_D_TO_ACC |=> acc_q[3] == 1'b0
         && acc_q[2:0] == $past(d_q)) else $error("read d wrong");
   a_read_stack_acc: assert property (
      run && op_q == OP_READ_STACK_PTR_TO_ACC |=> acc_q[3] == 1'b0
         && acc_q[2:0] == $past(stack_pointer))
      else $error("stack pointer read wrong");
   a_load_run_skip: assert property (
      in_exec && op_q == OP_LOAD_X_Y_IMM && xy_load_prev_q |=> skipped_q
         && $stable(x_q) && $stable(y_q)) else $error("load run not skipped");
   a_inc_skip_next: assert property (
      run && op_q == OP_INCREMENT_Y_SKIP && y_q == 4'hF
         |=> skip_pend_q && y_q == 4'h0) else $error("inc wrap no skip");
   a_dec_skip_next: assert property (
      run && op_q == OP_DECREMENT_Y_SKIP && y_q == 4'h0
         |=> skip_pend_q && y_q == 4'hF) else $error("dec wrap no skip");
   a_skip_freezes: assert property (
      in_exec && skip_now |=> $stable(acc_q) && $stable(x_q)
         && $stable(y_q) && $stable(e_q) && done_q
         && $stable(b_q) && $stable(z_q) && $stable(d_q))
      else $error("skipped instruction changed state");
   a_x_xor_mem: assert property (
      run && op_q == OP_LOAD_ACC_FROM_MEM |=> x_q == ($past(x_q)
         ^ $past(j_imm)) && acc_q == $past(mem_rd)) else $error("load wrong");
   a_done_timing: assert property (
      accept |=> !ready_q ##1 done_q && ready_q) else $error("bad timing");
   a_acc_to_y: assert property (
      run && op_q == OP_COPY_ACC_INTO_Y |=> y_q == $past(acc_q))
      else $error("y not loaded from acc");
   a_unpack_e: assert property (
      run && op_q == OP_UNPACK_E_INTO_AB |=> {b_q, acc_q} == $past(e_q))
      else $error("unpack wrong");
   a_write_d: assert property (
      run && op_q == OP_WRITE_ACC_TO_D |=> {1'b0, d_q} == ($past(acc_q)
         & 4'h7)) else $error("write d wrong");
   a_read_z_acc: assert property (
      run && op_q == OP_READ_Z_TO_ACC |=> acc_q == {2'b00, $past(z_q)})
      else $error("read z wrong");
   a_load_xy_imm: assert property (
      run && op_q == OP_LOAD_X_Y_IMM |=> {x_q, y_q} == $past(imm_q))
      else $error("x y immediate load wrong");
   a_load_z_imm: assert property (
      run && op_q == OP_LOAD_Z_IMM |=> {6'h00, z_q} == ($past(imm_q)
         & 8'h03)) else $error("z immediate load wrong");
   a_swap_acc_mem: assert property (
      run && op_q == OP_EXCHANGE_ACC_MEM |=> acc_q == $past(mem_rd)
         && x_q == ($past(x_q) ^ $past(j_imm))) else $error("swap wrong");
   a_store_x_xor: assert property (
      run && op_q == OP_STORE_ACC_TO_MEM |=> $stable(acc_q)
         && x_q == ($past(x_q) ^ $past(j_imm))) else $error("store wrong");
   a_exch_inc_skip: assert property (
      run && op_q == OP_EXCHANGE_ACC_MEM_INC && y_q == 4'hF
         |=> skip_pend_q && y_q == 4'h0) else $error("swap inc no skip");
   a_exch_dec_skip: assert property (
      run && op_q == OP_EXCHANGE_ACC_MEM_DEC && y_q == 4'h0
         |=> skip_pend_q && y_q == 4'hF) else $error("swap dec no skip");

   c_skip_taken: cover property (in_exec && skip_pend_q);
   c_load_run: cover property (in_exec && op_q == OP_LOAD_X_Y_IMM
      && xy_load_prev_q);
   c_exchange: cover property (run && op_q == OP_EXCHANGE_ACC_MEM_INC);
   c_dec_wrap: cover property (run && op_q == OP_DECREMENT_Y_SKIP
      && y_q == 4'h0);
   c_store: cover property (run && op_q == OP_STORE_ACC_TO_MEM);

endmodule : xfer_exec
`default_nettype wire

// ==== tb/dec_model.sv ====
// decoder model that offers instructions to the datapath
`timescale 1ns/1ps
`default_nettype none
module dec_model
   import xfer_pkg::*;
(
   // clock
   input wire logic clk,
   // instruction port
   input wire logic cmd_ready,
   output logic cmd_valid,
   output op_t cmd_op,
   output logic [IMM_W-1:0] cmd_imm,
   // core state
   output logic [STACK_PTR_W-1:0] stack_pointer
);
   initial begin
      cmd_valid = 1'b0;
      cmd_op = OP_OTHER;
      cmd_imm = 8'h00;
      stack_pointer = 3'h0;
   end

   // call just after a rising edge; ok is low if never taken
   task automatic issue(input op_t op, input logic [7:0] imm,
                        input logic [2:0] stk, output bit ok);
      bit r;
      ok = 1'b0;
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_imm <= imm;
      stack_pointer <= stk;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(negedge clk);
         r = cmd_ready;
         @(posedge clk);
         ok = r;
      end
      // stale immediate is inverted so it is never trusted
      cmd_valid <= 1'b0;
      cmd_imm <= ~imm;
   endtask : issue
endmodule : dec_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the transfer and ram-move datapath
`timescale 1ns/1ps
`default_nettype none
module tb
   import xfer_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cmd_valid, cmd_ready, done, skipped;
   op_t cmd_op;
   op_t op;
   logic [7:0] cmd_imm, reg_e;
   logic [2:0] stack_pointer, reg_d;
   logic [3:0] acc, reg_b, reg_x, reg_y;
   logic [1:0] reg_z;
   int miscompares = 0;
   int num_checks = 0;
   int a, b, x, y, z, d, e, pend, run_q;
   int mem [1024];
   op_t dop [9] = '{OP_LOAD_X_Y_IMM, OP_INCREMENT_Y_SKIP, OP_LOAD_X_Y_IMM,
      OP_LOAD_X_Y_IMM, OP_OTHER, OP_LOAD_X_Y_IMM, OP_LOAD_X_Y_IMM,
      OP_DECREMENT_Y_SKIP, OP_OTHER};
   int dimm [9] = '{8'h3F, 0, 8'h12, 8'h45, 0, 8'h60, 8'h77, 0, 0};

   always #5 clk = ~clk;

   xfer_exec dut_u (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_imm(cmd_imm), .cmd_ready(cmd_ready),
      .stack_pointer(stack_pointer), .done(done), .skipped(skipped),
      .acc(acc), .reg_b(reg_b), .reg_x(reg_x), .reg_y(reg_y),
      .reg_z(reg_z), .reg_d(reg_d), .reg_e(reg_e));
   dec_model dec_u (.clk(clk), .cmd_ready(cmd_ready),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_imm(cmd_imm),
      .stack_pointer(stack_pointer));

   task automatic stop_test();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [7:0] got, input int exp);
      num_checks++;
      if (got !== exp[7:0]) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp[7:0]);
      end
   endtask : chk

   // model one instruction, issue it, then compare at completion
   task automatic run(input op_t o, input int imm);
      int stk, j, ad, t, sk;
      bit ok;
      stk = $urandom_range(7, 0);
      j = imm % 16;
      ad = z * 256 + x * 16 + y;
      sk = pend || (o == OP_LOAD_X_Y_IMM && run_q);
      run_q = (o == OP_LOAD_X_Y_IMM);
      pend = 0;
      if (!sk) begin
         case (o)
            OP_COPY_B_INTO_ACC: a = b;
            OP_COPY_ACC_INTO_B: b = a;
            OP_COPY_Y_INTO_ACC: a = y;
            OP_COPY_ACC_INTO_Y: y = a;
            OP_PACK_AB_INTO_E: e = b * 16 + a;
            OP_UNPACK_E_INTO_AB: begin
               b = e / 16;
               a = e % 16;
            end
            OP_WRITE_ACC_TO_D: d = a % 8;
            OP_READ_D_TO_ACC: a = d;
            OP_READ_Z_TO_ACC: a = z;
            OP_READ_X_TO_ACC: a = x;
            OP_READ_STACK_PTR_TO_ACC: a = stk;
            OP_LOAD_X_Y_IMM: begin
               x = imm / 16;
               y = imm % 16;
            end
            OP_LOAD_Z_IMM: z = imm % 4;
            OP_LOAD_ACC_FROM_MEM: a = mem[ad];
            OP_STORE_ACC_TO_MEM: mem[ad] = a;
            OP_EXCHANGE_ACC_MEM, OP_EXCHANGE_ACC_MEM_DEC,
            OP_EXCHANGE_ACC_MEM_INC: begin
               t = a;
               a = mem[ad];
               mem[ad] = t;
            end
            default: ;
         endcase
         if (o >= OP_LOAD_ACC_FROM_MEM)
            x = x ^ j;
         if (o inside {OP_INCREMENT_Y_SKIP, OP_EXCHANGE_ACC_MEM_INC}) begin
            y = (y + 1) % 16;
            pend = (y == 0);
         end
         if (o inside {OP_DECREMENT_Y_SKIP, OP_EXCHANGE_ACC_MEM_DEC}) begin
            y = (y + 15) % 16;
            pend = (y == 15);
         end
      end
      @(posedge clk);
      dec_u.issue(o, imm[7:0], stk[2:0], ok);
      for (t = 1; t < 8; t++) begin
         @(negedge clk);
         if (done === 1'b1)
            break;
      end
      if (!ok || done !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, done, 1'b1);
         stop_test();
      end
      chk(t[7:0], EXEC_CYCLES);
      chk(skipped, sk);
      chk(acc, a);
      chk(reg_b, b);
      chk(reg_x, x);
      chk(reg_y, y);
      chk(reg_z, z);
      chk(reg_d, d);
      chk(reg_e, e);
      // done and skipped must be single-cycle pulses
      @(negedge clk);
      chk({done, skipped}, 0);
   endtask : run

   initial begin
      void'($urandom(65361));
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      // every nibble is written before any instruction reads memory
      for (int i = 0; i < 1024; i++) begin
         run(OP_LOAD_Z_IMM, i / 256);
         run(OP_LOAD_X_Y_IMM, i % 256);
         run(OP_COPY_Y_INTO_ACC, 0);
         run(OP_STORE_ACC_TO_MEM, 0);
      end
      foreach (dop[k])
         run(dop[k], dimm[k]);
      for (int i = 0; i < 1500; i++) begin
         op = op_t'($urandom_range(20, 0));
         if ($urandom_range(3, 0) == 0)
            op = OP_LOAD_X_Y_IMM;
         run(op, $urandom_range(255, 0));
      end
      stop_test();
   end
endmodule : tb
`default_nettype wire
